//--- pkg/timer_out_defs.svh
// Register offsets, reset values and timing counts of the timer output control block.
`ifndef TIMER_OUT_DEFS_SVH
`define TIMER_OUT_DEFS_SVH

`define N_CHAN          8
`define CNT_W           16
`define ADDR_W          8

`define OFF_START       8'h00
`define OFF_STOP        8'h04
`define OFF_STATUS      8'h08
`define OFF_MODE        8'h0C
`define OFF_POL         8'h10
`define OFF_OE          8'h14
`define OFF_LATCH       8'h18
`define OFF_CAPONE      8'h1C
`define OFF_CCS         8'h20
`define OFF_MSEL        8'h24
`define OFF_COUNT0      8'h40
`define OFF_COUNT_END   8'h60

`define RST_BYTE        8'h00
`define RST_MSEL        24'h000000
`define CNT_INIT        16'hFFFF
`define CNT_LOAD        16'h0000
`define CNT_STEP        16'h0001

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define CLK_PERIOD_NS   10
`define SLOW_PERIOD_NS  80
`define SLOW_DIV_CYC    ((`SLOW_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- pkg/timer_out_pkg.sv
// Types shared by the timer output control block.
package timer_out_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_RUN  = 3'h4
   } chan_state_t;

   typedef struct packed {
      logic mode;
      logic pol;
      logic oe;
   } out_ctl_t;

   typedef struct packed {
      logic master;
      logic slave;
   } irq_pair_t;

endpackage

//--- design/out_latch_cell.sv
// One channel output latch with its set, reset, toggle and software write paths.
`timescale 1ns/10ps
`include "timer_out_defs.svh"
module out_latch_cell
   import timer_out_pkg::*;
(
   input  wire logic      clk_sys_i,
   input  wire logic      reset_n_i,
   input  wire out_ctl_t  ctl_i,
   input  wire irq_pair_t irq_i,
   input  wire logic      sw_wr_i,
   input  wire logic      sw_data_i,
   output logic           latch_o
);

   logic set_req;
   logic clr_req;
   logic tgl_req;

   always_comb begin
      set_req = 1'b0;
      clr_req = 1'b0;
      tgl_req = 1'b0;
      if (!ctl_i.mode) begin
         tgl_req = irq_i.slave;                                  // [R6]
      end else if (irq_i.slave) begin
         // The slave event alone decides when both arrive together.
         set_req = ctl_i.pol;                                    // [R10] [R9]
         clr_req = !ctl_i.pol;                                   // [R10] [R8]
      end else if (irq_i.master) begin
         set_req = !ctl_i.pol;                                   // [R7] [R8]
         clr_req = ctl_i.pol;                                    // [R9]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         latch_o <= 1'b0;
      end else if (ctl_i.oe) begin
         if (tgl_req) begin
            latch_o <= !latch_o;                                 // [R6]
         end else if (set_req) begin
            latch_o <= 1'b1;                                     // [R11]
         end else if (clr_req) begin
            latch_o <= 1'b0;                                     // [R11]
         end
      end else if (sw_wr_i) begin
         latch_o <= sw_data_i;                                   // [R13]
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   a_toggle_on_slave: assert property (ctl_i.oe && !ctl_i.mode && irq_i.slave |=> latch_o != $past(latch_o)) // [R6]
      else $error("toggle mode did not toggle on slave event");
   a_toggle_ignores_master: assert property (ctl_i.oe && !ctl_i.mode && !irq_i.slave |=> $stable(latch_o)) // [R6]
      else $error("toggle mode moved without slave event");
   a_forward_set: assert property (ctl_i.oe && ctl_i.mode && !ctl_i.pol && irq_i.master && !irq_i.slave |=> latch_o) // [R8]
      else $error("forward master event did not set latch");
   a_reverse_set: assert property (ctl_i.oe && ctl_i.mode && ctl_i.pol && irq_i.slave |=> latch_o) // [R9]
      else $error("reverse slave event did not set latch");
   a_reverse_reset: assert property (ctl_i.oe && ctl_i.mode && ctl_i.pol && irq_i.master && !irq_i.slave |=> !latch_o) // [R9]
      else $error("reverse master event did not reset latch");
   a_both_slave_wins: assert property (ctl_i.oe && ctl_i.mode && !ctl_i.pol && irq_i.master && irq_i.slave |=> !latch_o) // [R10]
      else $error("simultaneous events did not reset latch");
   a_sw_write_blocked: assert property (ctl_i.oe && sw_wr_i && !irq_i.master && !irq_i.slave |=> $stable(latch_o)) // [R11]
      else $error("software write changed latch while enabled");
   a_sw_write_taken: assert property (!ctl_i.oe && sw_wr_i |=> latch_o == $past(sw_data_i)) // [R13]
      else $error("software write ignored while disabled");
   a_irq_blocked: assert property (!ctl_i.oe && !sw_wr_i |=> $stable(latch_o)) // [R13]
      else $error("event reached latch while disabled");

   c_both_events: cover property (ctl_i.oe && ctl_i.mode && irq_i.master && irq_i.slave);
   c_sw_write: cover property (!ctl_i.oe && sw_wr_i);

endmodule // out_latch_cell

//--- design/timer_out_ctrl.sv
// Timer channel start control and output pin control with an AXI4-Lite register port.
`timescale 1ns/10ps
`include "timer_out_defs.svh"
// How it works
// R1: In capture and one-count mode a 1 written to a channel's start trigger sets its enable status.
// R2: An enabled capture and one-count channel waits for a trigger while its count keeps its initial value.
// R3: On the trigger the count is loaded with zero and counting begins.
// R4: In capture and one-count mode the count runs on the operation clock as if count select were 0.
// R5: Counting starts only after the trigger is seen, so up to one count clock of sampling error exists.
// R6: In toggle mode polarity is ignored and only the slave event reaches the latch, toggling it.
// R7: In combination mode both master and slave events reach the latch and polarity applies.
// R8: With polarity 0 the master event sets the latch and the slave event resets it.
// R9: With polarity 1 the master event resets the latch and the slave event sets it.
// R10: When master and slave events coincide, the slave action wins and the master action is masked.
// R11: While output enable is 1 software writes to the latch are ignored and only events change it.
// R12: Software sets an initial level by clearing output enable first and then writing the latch.
// R13: While output enable is 0 software writes reach the latch and both events are blocked.
// R14: The latch reads back at all times and shows the current pin level.
// R15: Channels are 0 to 7, masters are 0, 2, 4 or 6, and a slave index lies above its master.
module timer_out_ctrl
   import timer_out_pkg::*;
(
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_n_i,
   input  wire logic [`ADDR_W-1:0]   s_axi_awaddr_i,
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   output logic [1:0]                s_axi_bresp_o,
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   input  wire logic [`ADDR_W-1:0]   s_axi_araddr_i,
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   output logic [31:0]               s_axi_rdata_o,
   output logic [1:0]                s_axi_rresp_o,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   input  wire logic [`N_CHAN-1:0]   chan_irq_i,
   input  wire logic [`N_CHAN-1:0]   external_timer_input_i,
   output logic [`N_CHAN-1:0]        output_latch_o
);

   function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
      return (a[1:0] == 2'h0) && ((a <= `OFF_MSEL) || ((a >= `OFF_COUNT0) && (a < `OFF_COUNT_END)));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic master_legal(input logic [2:0] m, input int p);
      return (m[0] == 1'b0) && (int'(m) < p);                    // [R15]
   endfunction

   logic [`ADDR_W-1:0]  aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                do_write;
   logic [31:0]         wr_byte;
   logic [7:0]          output_mode_select;
   logic [7:0]          output_polarity;
   logic [7:0]          output_enable;
   logic [7:0]          capone_mode;
   logic [7:0]          count_clock_select;
   logic [23:0]         master_sel;
   logic [7:0]          start_pulse;
   logic [7:0]          stop_pulse;
   logic                latch_wr;
   logic [7:0]          chan_enable_status;
   logic [7:0]          ext_q;
   logic [7:0]          trig_edge;
   logic [7:0]          slow_cnt;
   logic                slow_tick;
   logic [`CNT_W-1:0]   chan_count_value [`N_CHAN];
   chan_state_t         chan_state [`N_CHAN];
   irq_pair_t           irq_pair [`N_CHAN];
   logic [31:0]         rd_mux;

   // Write channel: address and data are taken in either order, then one write cycle follows.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `RESP_OKAY;
         aw_addr         <= `OFF_START;
         w_data          <= 32'h00000000;
         w_strb          <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_addr         <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
         end
         if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   assign do_write    = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   assign wr_byte     = merge(32'h00000000, w_data, w_strb);
   assign start_pulse = (do_write && aw_addr == `OFF_START) ? wr_byte[7:0] : 8'h00;
   assign stop_pulse  = (do_write && aw_addr == `OFF_STOP) ? wr_byte[7:0] : 8'h00;
   assign latch_wr    = do_write && (aw_addr == `OFF_LATCH) && w_strb[0];

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         output_mode_select <= `RST_BYTE;
         output_polarity    <= `RST_BYTE;
         output_enable      <= `RST_BYTE;
         capone_mode        <= `RST_BYTE;
         count_clock_select <= `RST_BYTE;
         master_sel         <= `RST_MSEL;
      end else if (do_write) begin
         unique case (aw_addr)
            `OFF_MODE:   output_mode_select <= w_strb[0] ? w_data[7:0] : output_mode_select;
            `OFF_POL:    output_polarity    <= w_strb[0] ? w_data[7:0] : output_polarity;
            `OFF_OE:     output_enable      <= w_strb[0] ? w_data[7:0] : output_enable;
            `OFF_CAPONE: capone_mode        <= w_strb[0] ? w_data[7:0] : capone_mode;
            `OFF_CCS:    count_clock_select <= w_strb[0] ? w_data[7:0] : count_clock_select;
            `OFF_MSEL:   master_sel         <= 24'(merge({8'h0, master_sel}, w_data, w_strb));
            default:     ;
         endcase
      end
   end

   // Read channel: data one cycle after the address is taken.
   always_comb begin
      rd_mux = 32'h00000000;
      if (s_axi_araddr_i >= `OFF_COUNT0) begin
         rd_mux[`CNT_W-1:0] = chan_count_value[s_axi_araddr_i[4:2]];
      end else begin
         unique case (s_axi_araddr_i)
            `OFF_STATUS: rd_mux[7:0]  = chan_enable_status;
            `OFF_MODE:   rd_mux[7:0]  = output_mode_select;
            `OFF_POL:    rd_mux[7:0]  = output_polarity;
            `OFF_OE:     rd_mux[7:0]  = output_enable;
            `OFF_LATCH:  rd_mux[7:0]  = output_latch_o;          // [R14]
            `OFF_CAPONE: rd_mux[7:0]  = capone_mode;
            `OFF_CCS:    rd_mux[7:0]  = count_clock_select;
            `OFF_MSEL:   rd_mux[23:0] = master_sel;
            default:     rd_mux       = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= `RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= is_mapped(s_axi_araddr_i) ? rd_mux : 32'h00000000;
         s_axi_rresp_o   <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Slow count clock for channels outside capture and one-count mode.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         slow_cnt  <= 8'h00;
         slow_tick <= 1'b0;
      end else if (slow_cnt == 8'(`SLOW_DIV_CYC - 1)) begin
         slow_cnt  <= 8'h00;
         slow_tick <= 1'b1;
      end else begin
         slow_cnt  <= slow_cnt + 8'h01;
         slow_tick <= 1'b0;
      end
   end

   // The trigger rise is taken at the first clock edge that sees it, which is the sampling error users must allow for.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ext_q <= 8'h00;
      end else begin
         ext_q <= external_timer_input_i;                        // [R5]
      end
   end
   assign trig_edge = external_timer_input_i & ~ext_q;           // [R5]

   genvar n;
   generate
      for (n = 0; n < `N_CHAN; n++) begin : g_chan
         logic tick;
         assign tick = capone_mode[n] ? 1'b1 : (count_clock_select[n] ? slow_tick : 1'b1); // [R4]
         assign chan_enable_status[n] = (chan_state[n] != ST_IDLE);

         always_ff @(posedge clk_sys_i) begin
            if (!reset_n_i) begin
               chan_state[n]       <= ST_IDLE;
               chan_count_value[n] <= `CNT_INIT;
            end else if (stop_pulse[n]) begin
               chan_state[n] <= ST_IDLE;
            end else begin
               unique case (chan_state[n])
                  ST_IDLE: if (start_pulse[n]) begin
                     if (capone_mode[n]) begin
                        chan_state[n] <= ST_WAIT;                // [R1]
                     end else begin
                        chan_state[n]       <= ST_RUN;
                        chan_count_value[n] <= `CNT_LOAD;
                     end
                  end
                  ST_WAIT: if (trig_edge[n]) begin              // [R2]
                     chan_state[n]       <= ST_RUN;
                     chan_count_value[n] <= `CNT_LOAD;           // [R3]
                  end
                  ST_RUN: if (tick) begin
                     chan_count_value[n] <= chan_count_value[n] + `CNT_STEP; // [R4]
                  end
                  default: chan_state[n] <= ST_IDLE;
               endcase
            end
         end

         always_comb begin
            irq_pair[n].slave  = chan_irq_i[n];
            irq_pair[n].master = 1'b0;
            if (master_legal(master_sel[n*3 +: 3], n)) begin     // [R15]
               irq_pair[n].master = chan_irq_i[master_sel[n*3 +: 3]];
            end
         end

         out_latch_cell u_cell (
            .clk_sys_i (clk_sys_i),
            .reset_n_i (reset_n_i),
            .ctl_i     ('{mode: output_mode_select[n], pol: output_polarity[n],
                          oe: output_enable[n]}),
            .irq_i     (irq_pair[n]),
            .sw_wr_i   (latch_wr),
            .sw_data_i (w_data[n]),
            .latch_o   (output_latch_o[n])
         );
      end
   endgenerate

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   a_start_enables: assert property (start_pulse[0] && capone_mode[0] && !stop_pulse[0]
                                     && chan_state[0] == ST_IDLE |=> chan_state[0] == ST_WAIT ##0 chan_enable_status[0]) // [R1]
      else $error("start write did not enable channel");
   a_wait_holds: assert property (chan_state[0] == ST_WAIT && !trig_edge[0] |=> $stable(chan_count_value[0])) // [R2]
      else $error("count moved while waiting for trigger");
   a_trigger_loads: assert property (chan_state[0] == ST_WAIT && trig_edge[0] && !stop_pulse[0]
                                     |=> chan_count_value[0] == `CNT_LOAD && chan_state[0] == ST_RUN) // [R3]
      else $error("trigger did not load zero");
   a_capone_counts: assert property (chan_state[0] == ST_RUN && capone_mode[0] && !stop_pulse[0]
                                     |=> chan_count_value[0] == $past(chan_count_value[0]) + `CNT_STEP) // [R4]
      else $error("capture one-count did not count every clock");
   a_no_early_start: assert property (chan_state[0] == ST_WAIT // [R5]
                                      && (!external_timer_input_i[0] || ext_q[0])
                                      |=> chan_state[0] != ST_RUN)
      else $error("count started without a trigger edge");
   a_latch_readback: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `OFF_LATCH
                                      |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(output_latch_o)) // [R14]
      else $error("latch read did not return pin level");
   a_bad_master: assert property (irq_pair[1].master == // [R15]
                                  (master_sel[5:3] == 3'h0 && chan_irq_i[0]))
      else $error("illegal master reached channel one");
   a_write_response: assert property (do_write |=> s_axi_bvalid_o ##1 !do_write)
      else $error("write response missing");

   c_trigger_seen: cover property (chan_state[0] == ST_WAIT ##1 chan_state[0] == ST_RUN);
   c_read_latch: cover property (s_axi_rvalid_o && s_axi_rready_i);
   c_count_run: cover property ((chan_state[0] == ST_RUN) [*3]);

endmodule // timer_out_ctrl

//--- sim/pin_side_model.sv
// Model of the circuit on the timer pins: it sees the outputs and drives the trigger inputs.
`timescale 1ns/10ps
module pin_side_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] output_latch_i,
   output logic      [7:0] external_timer_input_o
);
   // Inputs idle low, so each rise is a fresh trigger.
   initial external_timer_input_o = 8'h00;

   // The level is held four clocks, so the edge detector on the system clock cannot miss it.
   task automatic fire(input int ch);
      @(posedge clk_sys_i);
      external_timer_input_o[ch] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      external_timer_input_o[ch] <= 1'b0;
   endtask
endmodule // pin_side_model

//--- sim/timer_out_ctrl_tb_top.sv
// Self-checking bench for the timer output control block.
`timescale 1ns/10ps
`include "timer_out_defs.svh"
module timer_out_ctrl_tb_top;
   logic        clk_sys_i;
   logic        reset_n_i;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [7:0]  irq;
   logic [7:0]  trig;
   logic [7:0]  pins;
   int          bad_count = 0;
   int          compares = 0;
   int          cyc = 0;
   int          rcyc = 0;

   timer_out_ctrl DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .chan_irq_i(irq),
      .external_timer_input_i(trig), .output_latch_o(pins));

   pin_side_model PART (.clk_sys_i(clk_sys_i), .output_latch_i(pins),
      .external_timer_input_o(trig));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic final_report;
      $display("Mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The ceiling is more than twenty times the length of the full sequence.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_sys_i);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clk_sys_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge clk_sys_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clk_sys_i);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            rcyc = cyc;
         end
         if (rvalid) begin
            rready <= 1'b0;
            d = rdata;
            chk({30'h0, rresp}, {30'h0, er});
            break;
         end
      end
   endtask

   // An event pulse lasts one clock; the latch is looked at once it has landed.
   task automatic pulse(input logic [7:0] m, input logic exp1);
      @(posedge clk_sys_i);
      irq <= m;
      @(posedge clk_sys_i);
      irq <= 8'h00;
      @(posedge clk_sys_i);
      chk({31'h0, pins[1]}, {31'h0, exp1});
   endtask

   task automatic t_reset;
      logic [31:0] d;
      chk({24'h0, pins}, 32'h0);
      rd(`OFF_STATUS, `RESP_OKAY, d);
      chk(d, 32'h0);
      rd(`OFF_COUNT0 + 8'h0C, `RESP_OKAY, d);
      chk(d, 32'hFFFF);
   endtask

   task automatic t_sw_latch;
      logic [31:0] d;
      wr(`OFF_OE, 32'h0, `RESP_OKAY);
      wr(`OFF_LATCH, 32'hA5, `RESP_OKAY);
      chk({24'h0, pins}, 32'hA5);
      pulse(8'h03, 1'b0);
      rd(`OFF_LATCH, `RESP_OKAY, d);
      chk(d, 32'hA5);
      wr(`OFF_OE, 32'hFF, `RESP_OKAY);
      wr(`OFF_LATCH, 32'h5A, `RESP_OKAY);
      chk({24'h0, pins}, 32'hA5);
      rd(`OFF_LATCH, `RESP_OKAY, d);
      chk(d, 32'hA5);
   endtask

   task automatic t_comb;
      wr(`OFF_OE, 32'h0, `RESP_OKAY);
      wr(`OFF_LATCH, 32'h0, `RESP_OKAY);
      wr(`OFF_MODE, 32'h2, `RESP_OKAY);
      wr(`OFF_POL, 32'h0, `RESP_OKAY);
      wr(`OFF_OE, 32'h2, `RESP_OKAY);
      pulse(8'h01, 1'b1);
      pulse(8'h02, 1'b0);
      pulse(8'h01, 1'b1);
      pulse(8'h03, 1'b0);
      wr(`OFF_POL, 32'h2, `RESP_OKAY);
      pulse(8'h02, 1'b1);
      pulse(8'h01, 1'b0);
      pulse(8'h03, 1'b1);
      // A master index above the slave must never steer the latch.
      wr(`OFF_MSEL, 32'h10, `RESP_OKAY);
      pulse(8'h04, 1'b1);
      pulse(8'h01, 1'b1);
      wr(`OFF_MSEL, 32'h0, `RESP_OKAY);
   endtask

   task automatic t_toggle;
      wr(`OFF_MODE, 32'h0, `RESP_OKAY);
      pulse(8'h01, 1'b1);
      pulse(8'h02, 1'b0);
      pulse(8'h02, 1'b1);
   endtask

   task automatic t_capone;
      logic [31:0] d;
      logic [31:0] c0;
      logic [31:0] c1;
      int          k0;
      wr(`OFF_CAPONE, 32'h1, `RESP_OKAY);
      wr(`OFF_CCS, 32'h1, `RESP_OKAY);
      wr(`OFF_START, 32'h1, `RESP_OKAY);
      rd(`OFF_STATUS, `RESP_OKAY, d);
      chk(d, 32'h1);
      repeat (6) @(posedge clk_sys_i);
      rd(`OFF_COUNT0, `RESP_OKAY, d);
      chk(d, 32'hFFFF);
      PART.fire(0);
      rd(`OFF_COUNT0, `RESP_OKAY, c0);
      k0 = rcyc;
      repeat (7) @(posedge clk_sys_i);
      rd(`OFF_COUNT0, `RESP_OKAY, c1);
      chk({31'h0, c0 < 32'h10}, 32'h1);
      chk(c1 - c0, 32'(rcyc - k0));
      wr(`OFF_STOP, 32'h1, `RESP_OKAY);
      rd(`OFF_STATUS, `RESP_OKAY, d);
      chk(d, 32'h0);
      // Outside capture and one-count mode the slow select applies; a 16-cycle gap spans two ticks.
      wr(`OFF_CAPONE, 32'h0, `RESP_OKAY);
      wr(`OFF_START, 32'h1, `RESP_OKAY);
      rd(`OFF_COUNT0, `RESP_OKAY, c0);
      k0 = rcyc;
      repeat (13) @(posedge clk_sys_i);
      rd(`OFF_COUNT0, `RESP_OKAY, c1);
      chk(c1 - c0, 32'((rcyc - k0) / `SLOW_DIV_CYC));
   endtask

   task automatic t_unmapped;
      logic [31:0] d;
      wr(8'h30, 32'hFF, `RESP_SLVERR);
      rd(8'h30, `RESP_SLVERR, d);
      chk(d, 32'h0);
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb, irq, wdata} = 60'h0;
      reset_n_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_sw_latch();
      t_comb();
      t_toggle();
      t_capone();
      t_unmapped();
      final_report();
   end
endmodule // timer_out_ctrl_tb_top
